// ===== inc/flt_pkg.sv
// Summary of operation
// [R01] enable low: shutdown, everything off, output disconnected from supply
// [R02] enable high: start pump, sinks on only after output reaches regulation
// [R03] enabled with select low: torch level from torch_current_resistor
// [R04] enabled with select high: flash level from flash_current_resistor
// [R05] select high beyond one second: timeout, all sinks off
// [R06] during timeout pump keeps output up while sinks stay off
// [R07] timeout cleared only by enable low; next enable high resumes
// [R08] timeout protection inactive while transmit interrupt is high
// [R09] transmit interrupt high in flash drops to torch level, restores after
// [R10] sink-disable low: four sinks active; high: fourth_current_sink off
// [R11] host applies supply_input_voltage before raising enable
// [R12] disabled fourth sink pin tied to pump_output_voltage by board
// [R13] thermal shutdown at hot indication, resume once below cool threshold
// [R14] gain steps only upward, 125 ms per step torch, 2 ms flash
// [R15] gain held while enabled, back to minimum after shutdown; the code also resets it in thermal shutdown with enable high
// [R16] timeout timer cleared unless flash current is really being driven
`default_nettype none
package flt_pkg;

  // timing
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned TIMEOUT_S      = 1;
  localparam int unsigned TORCH_STEP_MS  = 125;
  localparam int unsigned FLASH_STEP_MS  = 2;
  localparam logic [31:0] TIMEOUT_CYC    = 32'(TIMEOUT_S * CLK_HZ);
  localparam logic [31:0] TORCH_STEP_CYC = 32'(TORCH_STEP_MS * (CLK_HZ / 1000));
  localparam logic [31:0] FLASH_STEP_CYC = 32'(FLASH_STEP_MS * (CLK_HZ / 1000));
  localparam logic [31:0] CNT_RST        = 32'h0000_0000;

  // sink patterns
  localparam logic [3:0]  SINKS_ALL      = 4'hF;
  localparam logic [3:0]  SINKS_THREE    = 4'h7;
  localparam logic [3:0]  SINKS_NONE     = 4'h0;

  typedef enum logic [1:0]
  {
    GAIN_1X   = 2'b00,
    GAIN_1P5X = 2'b01,
    GAIN_2X   = 2'b10
  } flt_gain_t;

  typedef enum logic [1:0]
  {
    ST_OFF   = 2'b00,
    ST_START = 2'b01,
    ST_RUN   = 2'b10,
    ST_HOT   = 2'b11
  } flt_state_t;

  typedef struct packed
  {
    logic enable;
    logic torch_flash;
    logic tx_hold;
    logic sink4_off;
  } flt_pins_t;

  typedef struct packed
  {
    logic pump_output_voltage_in_reg;
    logic temp_hot;
    logic temp_cool;
    logic gain_need_up;
  } flt_sense_t;

  typedef struct packed
  {
    logic       core_on;
    logic       pump_en;
    logic       output_to_supply;
    logic       flash_level;
    logic [3:0] led_current_sinks;
  } flt_drive_t;

  localparam flt_pins_t  PINS_RST  = flt_pins_t'(4'h0);
  localparam flt_sense_t SENSE_RST = flt_sense_t'(4'h0);
  localparam flt_drive_t DRIVE_OFF = flt_drive_t'(8'h00);
  localparam flt_gain_t  GAIN_RST  = GAIN_1X;
  localparam flt_state_t STATE_RST = ST_OFF;

endpackage
`default_nettype wire

// ===== logic/flt_gain_step.sv
`timescale 1ns/1ps
`default_nettype none
module flt_gain_step
#(
  parameter logic [31:0] TORCH_STEP_CYC = flt_pkg::TORCH_STEP_CYC,
  parameter logic [31:0] FLASH_STEP_CYC = flt_pkg::FLASH_STEP_CYC
)
(
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  // control
  input  wire logic              i_active,
  input  wire logic              i_flash,
  input  wire logic              i_need_up,
  // gain
  output var  flt_pkg::flt_gain_t o_gain
);
  import flt_pkg::*;

  logic [31:0] step_cnt;
  logic [31:0] next_step_cnt;
  flt_gain_t   next_gain;
  logic [31:0] step_lim;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    step_lim      = i_flash ? FLASH_STEP_CYC : TORCH_STEP_CYC; // R14
    next_step_cnt = CNT_RST;
    next_gain     = o_gain;
    if (!i_active)
    begin
      next_gain = GAIN_1X; // R15
    end
    else if (i_need_up && (o_gain != GAIN_2X))
    begin
      if (step_cnt >= step_lim - 32'h1)
      begin
        next_gain = (o_gain == GAIN_1X) ? GAIN_1P5X : GAIN_2X; // R14
      end
      else
      begin
        next_step_cnt = step_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      step_cnt <= CNT_RST;
      o_gain   <= GAIN_RST;
    end
    else
    begin
      step_cnt <= next_step_cnt;
      o_gain   <= next_gain;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  gain_upward_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R14
    i_active |=> (o_gain >= $past(o_gain)))
    else $error("gain stepped downward while enabled");

  gain_reset_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R15
    !i_active |=> (o_gain == GAIN_1X))
    else $error("gain not back to minimum after shutdown");

  gain_wait_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R14
    (i_active && $past(i_active) && (o_gain != $past(o_gain)))
    |-> ($past(step_cnt) >= $past(step_lim) - 32'h1))
    else $error("gain stepped before its step time");

endmodule
`default_nettype wire

// ===== logic/flt_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module flt_mode_ctrl
#(
  parameter logic [31:0] TIMEOUT_CYC    = flt_pkg::TIMEOUT_CYC,
  parameter logic [31:0] TORCH_STEP_CYC = flt_pkg::TORCH_STEP_CYC,
  parameter logic [31:0] FLASH_STEP_CYC = flt_pkg::FLASH_STEP_CYC
)
(
  // clock and reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst_n,
  // logic control pins, asynchronous
  input  wire flt_pkg::flt_pins_t  i_pins,
  // analog indications, asynchronous
  input  wire flt_pkg::flt_sense_t i_sense,
  // power stage control
  output var  flt_pkg::flt_drive_t o_drive,
  output var  flt_pkg::flt_gain_t  o_gain,
  // status
  output var  logic                o_timeout,
  output var  logic                o_thermal_sd
);
  import flt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  flt_pins_t  pin_s1;
  flt_pins_t  pin_s2;
  flt_sense_t sense_s1;
  flt_sense_t sense_s2;
  flt_pins_t  next_pin_s1;
  flt_pins_t  next_pin_s2;
  flt_sense_t next_sense_s1;
  flt_sense_t next_sense_s2;

  always_comb
  begin
    next_pin_s1   = i_pins;
    next_pin_s2   = pin_s1;
    next_sense_s1 = i_sense;
    next_sense_s2 = sense_s1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      pin_s1   <= PINS_RST;
      pin_s2   <= PINS_RST;
      sense_s1 <= SENSE_RST;
      sense_s2 <= SENSE_RST;
    end
    else
    begin
      pin_s1   <= next_pin_s1;
      pin_s2   <= next_pin_s2;
      sense_s1 <= next_sense_s1;
      sense_s2 <= next_sense_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // thermal shutdown with hysteresis

  logic next_thermal_sd;

  always_comb
  begin
    next_thermal_sd = o_thermal_sd;
    if (sense_s2.temp_hot)
    begin
      next_thermal_sd = 1'b1; // R13
    end
    else if (sense_s2.temp_cool)
    begin
      next_thermal_sd = 1'b0; // R13
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_thermal_sd <= 1'b0;
    end
    else
    begin
      o_thermal_sd <= next_thermal_sd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start-up sequencer

  flt_state_t state;
  flt_state_t next_state;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_OFF:
      begin
        if (pin_s2.enable)
        begin
          next_state = ST_START; // R02
        end
      end
      ST_START:
      begin
        if (!pin_s2.enable)
        begin
          next_state = ST_OFF; // R01
        end
        else if (o_thermal_sd)
        begin
          next_state = ST_HOT; // R13
        end
        else if (sense_s2.pump_output_voltage_in_reg)
        begin
          next_state = ST_RUN; // R02
        end
      end
      ST_RUN:
      begin
        if (!pin_s2.enable)
        begin
          next_state = ST_OFF; // R01
        end
        else if (o_thermal_sd)
        begin
          next_state = ST_HOT; // R13
        end
      end
      ST_HOT:
      begin
        if (!pin_s2.enable)
        begin
          next_state = ST_OFF; // R01
        end
        else if (!o_thermal_sd)
        begin
          next_state = ST_START; // R13
        end
      end
      default:
      begin
        next_state = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      state <= STATE_RST;
    end
    else
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash timeout

  logic [31:0] tmr;
  logic [31:0] next_tmr;
  logic        next_timeout;
  logic        flash_active;

  always_comb
  begin
    // counts only while flash current really flows
    flash_active = (state == ST_RUN) && pin_s2.torch_flash
                   && !pin_s2.tx_hold && !o_timeout; // R16 R08
    next_tmr     = CNT_RST; // R16
    next_timeout = o_timeout;
    if (flash_active)
    begin
      next_tmr = tmr + 32'h1;
    end
    if (flash_active && (tmr == TIMEOUT_CYC - 32'h1))
    begin
      next_timeout = 1'b1; // R05
      next_tmr     = CNT_RST;
    end
    else if (!pin_s2.enable)
    begin
      next_timeout = 1'b0; // R07
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      tmr       <= CNT_RST;
      o_timeout <= 1'b0;
    end
    else
    begin
      tmr       <= next_tmr;
      o_timeout <= next_timeout;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power stage and sink drive

  flt_drive_t next_drive;
  logic       pump_on;

  always_comb
  begin
    pump_on    = (state == ST_START) || (state == ST_RUN);
    next_drive = DRIVE_OFF; // R01
    next_drive.core_on          = (state != ST_OFF);
    next_drive.pump_en          = pump_on; // R02 R06
    next_drive.output_to_supply = pump_on;
    if ((state == ST_RUN) && !o_timeout) // R05 R06
    begin
      next_drive.led_current_sinks = pin_s2.sink4_off ? SINKS_THREE : SINKS_ALL; // R10
      next_drive.flash_level       = pin_s2.torch_flash && !pin_s2.tx_hold; // R03 R04 R09
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_drive <= DRIVE_OFF;
    end
    else
    begin
      o_drive <= next_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // charge-pump gain

  flt_gain_step
  #(
    .TORCH_STEP_CYC (TORCH_STEP_CYC),
    .FLASH_STEP_CYC (FLASH_STEP_CYC)
  )
  u_gain
  (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_active  (pump_on),
    .i_flash   (next_drive.flash_level),
    .i_need_up (sense_s2.gain_need_up),
    .o_gain    (o_gain)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  shutdown_all_off_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R01
    !pin_s2.enable |=> ##1 (o_drive == DRIVE_OFF))
    else $error("output stage not off after enable low");

  sinks_wait_reg_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R02
    ((state == ST_START) && !sense_s2.pump_output_voltage_in_reg) |=> (state != ST_RUN))
    else $error("sinks enabled before output regulation");

  torch_level_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R03
    !pin_s2.torch_flash |=> !o_drive.flash_level)
    else $error("flash level with select low");

  flash_level_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R04
    ((state == ST_RUN) && !o_timeout && pin_s2.torch_flash && !pin_s2.tx_hold)
    |=> (o_drive.flash_level && (o_drive.led_current_sinks != SINKS_NONE)))
    else $error("flash level missing in flash mode");

  tx_torch_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R09
    pin_s2.tx_hold |=> !o_drive.flash_level)
    else $error("flash level during transmit interrupt");

  timeout_fire_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R05
    (flash_active && (tmr == TIMEOUT_CYC - 32'h1)) |=> o_timeout ##1 (o_drive.led_current_sinks == SINKS_NONE))
    else $error("timeout not raised at its count");

  timeout_pump_on_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R06
    (o_timeout && (state == ST_RUN)) |=> (o_drive.pump_en && (o_drive.led_current_sinks == SINKS_NONE)))
    else $error("timeout drops output or leaves sinks on");

  timeout_hold_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R07
    (o_timeout && pin_s2.enable) |=> o_timeout)
    else $error("timeout cleared without enable low");

  timeout_clear_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R07
    (!pin_s2.enable && !$past(pin_s2.enable)) |=> !o_timeout)
    else $error("timeout not cleared by enable low");

  timer_idle_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R08
    (!pin_s2.torch_flash || pin_s2.tx_hold) |=> (tmr == CNT_RST))
    else $error("timeout timer running outside flash current");

  sink4_off_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R10
    ((state == ST_RUN) && !o_timeout && pin_s2.sink4_off) |=> (o_drive.led_current_sinks == SINKS_THREE))
    else $error("fourth sink not disabled");

  thermal_hyst_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R13
    (o_thermal_sd && !sense_s2.temp_cool) |=> o_thermal_sd ##1 (state != ST_RUN))
    else $error("thermal shutdown released above cool threshold");

endmodule
`default_nettype wire

// ===== test/flt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module flt_host_model
(
  // clock
  input  wire logic               i_sys_clk,
  // logic control pins toward the device
  output var  flt_pkg::flt_pins_t o_pins
);
  import flt_pkg::*;

  logic supply_on;

  initial
  begin
    supply_on = 1'b0;
    o_pins    = PINS_RST;
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply comes up before any enable is allowed through
  task automatic power_up();
    @(negedge i_sys_clk);
    supply_on = 1'b1;
  endtask

  // pins change only after a falling edge, held until the next call
  // a disabled fourth sink is strapped to the pump output on the board
  task automatic put(input logic en, input logic tf, input logic tx, input logic s4);
    @(negedge i_sys_clk);
    o_pins = '{enable: en & supply_on, torch_flash: tf, tx_hold: tx, sink4_off: s4};
  endtask
endmodule
`default_nettype wire

// ===== test/flt_mode_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module flt_mode_ctrl_bench;
  import flt_pkg::*;

  localparam int TMO = 20;

  logic        i_sys_clk;
  logic        i_rst_n;
  flt_pins_t   pins;
  flt_sense_t  sense;
  flt_drive_t  drive;
  flt_gain_t   gain;
  logic        timeout;
  logic        thermal_sd;
  int          bad_count;
  int          n_tests;
  int          m_tmr;
  logic        m_tmo;
  logic        m_hot;
  logic [31:0] seed;
  logic [31:0] r;

  flt_host_model i_flt_host_model
  (
    .i_sys_clk (i_sys_clk),
    .o_pins    (pins)
  );

  flt_mode_ctrl #(.TIMEOUT_CYC(32'd20), .TORCH_STEP_CYC(32'd12), .FLASH_STEP_CYC(32'd4))
  i_flt_mode_ctrl
  (
    .i_sys_clk    (i_sys_clk),
    .i_rst_n      (i_rst_n),
    .i_pins       (pins),
    .i_sense      (sense),
    .o_drive      (drive),
    .o_gain       (gain),
    .o_timeout    (timeout),
    .o_thermal_sd (thermal_sd)
  );

  initial
  begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference model: flash timer, timeout latch, thermal hysteresis
  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      m_hot = 1'b0;
    else if (sense.temp_hot)
      m_hot = 1'b1;
    else if (sense.temp_cool)
      m_hot = 1'b0;
    if (!i_rst_n || !pins.enable)
    begin
      m_tmr = 0;
      m_tmo = 1'b0;
    end
    else if (sense.pump_output_voltage_in_reg && !m_hot && pins.torch_flash && !pins.tx_hold && !m_tmo)
    begin
      m_tmr = m_tmr + 1;
      m_tmo = (m_tmr >= TMO);
    end
    else
      m_tmr = 0;
  end

  function automatic logic [7:0] exp_drive();
    if (!pins.enable)
      return 8'h00;
    if (m_hot)
      return 8'h80;
    if (!sense.pump_output_voltage_in_reg)
      return 8'hE0;
    return {3'b111, pins.torch_flash & ~pins.tx_hold & ~m_tmo,
            m_tmo ? 4'h0 : (pins.sink4_off ? 4'h7 : 4'hF)};
  endfunction

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    bad_count = 0;
    n_tests   = 0;
    seed      = 32'hAC698821;
    i_rst_n   = 1'b0;
    sense     = SENSE_RST;
    settle(20);
    chk(drive, 8'h00, "reset drive");
    chk({6'h00, gain}, 8'h00, "reset gain");
    i_rst_n = 1'b1;
    i_flt_host_model.power_up();
    i_flt_host_model.put(1'b1, 1'b0, 1'b0, 1'b0);
    settle(8);
    chk(drive, exp_drive(), "pump before regulation");
    sense.pump_output_voltage_in_reg = 1'b1;
    settle(8);
    chk(drive, exp_drive(), "torch level");
    i_flt_host_model.put(1'b1, 1'b0, 1'b0, 1'b1);
    settle(8);
    chk(drive, exp_drive(), "three sinks");
    done("startup");

    i_flt_host_model.put(1'b1, 1'b1, 1'b0, 1'b0);
    settle(6);
    chk(drive, exp_drive(), "flash level");
    i_flt_host_model.put(1'b1, 1'b1, 1'b1, 1'b0);
    settle(40);
    chk(drive, exp_drive(), "transmit torch level");
    chk({7'h00, timeout}, 8'h00, "no timeout in transmit");
    i_flt_host_model.put(1'b1, 1'b1, 1'b0, 1'b0);
    settle(8);
    chk(drive, exp_drive(), "flash restored");
    settle(20);
    chk(drive & 8'hEF, exp_drive() & 8'hEF, "timeout sinks off pump on");
    chk({7'h00, timeout}, {7'h00, m_tmo}, "timeout flag");
    i_flt_host_model.put(1'b0, 1'b1, 1'b0, 1'b0);
    settle(8);
    chk({drive[7:4], 3'h0, timeout}, 8'h00, "enable low clears");
    i_flt_host_model.put(1'b1, 1'b0, 1'b0, 1'b0);
    settle(8);
    chk(drive, exp_drive(), "normal after re-enable");
    done("flash timeout");

    sense.temp_hot = 1'b1;
    settle(8);
    chk({drive[7:1], thermal_sd}, (exp_drive() & 8'hFE) | 8'h01, "thermal shutdown");
    sense.temp_hot  = 1'b0;
    sense.temp_cool = 1'b1;
    settle(10);
    chk({drive[7:1], thermal_sd}, exp_drive() & 8'hFE, "thermal resume");
    sense.temp_cool = 1'b0;
    done("thermal");

    sense.gain_need_up = 1'b1;
    settle(8);
    chk({6'h00, gain}, {6'h00, GAIN_1X}, "torch step not yet");
    settle(12);
    chk({6'h00, gain}, {6'h00, GAIN_1P5X}, "torch first step");
    settle(20);
    chk({6'h00, gain}, {6'h00, GAIN_2X}, "torch second step");
    sense.gain_need_up = 1'b0;
    settle(20);
    chk({6'h00, gain}, {6'h00, GAIN_2X}, "gain held");
    i_flt_host_model.put(1'b0, 1'b0, 1'b0, 1'b0);
    settle(8);
    chk({6'h00, gain}, {6'h00, GAIN_1X}, "gain reset by shutdown");
    i_flt_host_model.put(1'b1, 1'b1, 1'b0, 1'b0);
    settle(6);
    sense.gain_need_up = 1'b1;
    settle(14);
    chk({6'h00, gain}, {6'h00, GAIN_2X}, "flash step rate");
    sense.gain_need_up = 1'b0;
    i_flt_host_model.put(1'b0, 1'b0, 1'b0, 1'b0);
    settle(8);
    done("gain");

    i_flt_host_model.put(1'b1, 1'b0, 1'b0, 1'b0);
    settle(8);
    repeat (8)
    begin
      r = xs();
      i_flt_host_model.put(1'b1, 1'b0, r[0], r[1]);
      settle(6);
      chk(drive, exp_drive(), "random torch pins");
    end
    done("random");
    tally_and_finish();
  end
endmodule
`default_nettype wire
